// [rtl/kpgf_top.sv]
/*
  Pointer, ghost-key filter, debounce gating and software sequencer reset.
  Assumes key sense levels arrive asynchronously from the analog matrix and
  that register byte strobes come from an I2C target on the same clock.
  The settle count is the package constant; the sequencer has no other timer.
*/
// Operation
// [R1] Multi-master hosts use repeated start before reads
// [R2] Pointer advances after every data byte
// [R3] Advance applies only within multi-byte bursts
// [R4] Suppress third key that creates ghost
// [R5] Accept any keys absent ghosts and full queue
// [R6] Debounce runs only while a key pressed; the code also starts it while any key is still accepted in stable
// [R7] Configuration top bit reads one normally
// [R8] Clearing then setting top bit resets sequencer
// [R9] Read advance: 0x00 holds, 0x06 wraps, else increments; the code also wraps every pointer above 0x06 to 0x00
// [R10] Sequencer held reset while top bit zero
module kpgf_top
  import kpgf_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic                        cmd_valid,
  input  wire logic [7:0]                  cmd_byte,
  input  wire logic                        wr_valid,
  input  wire logic [7:0]                  wr_data,
  input  wire logic                        rd_done,
  input  wire logic                        burst,
  input  wire logic [kpgf_pkg::ROWS*kpgf_pkg::COLS-1:0] key_sense,
  input  wire logic                        queue_full,
  output logic      [7:0]                  ptr,
  output logic      [7:0]                  cfg,
  output logic      [kpgf_pkg::ROWS*kpgf_pkg::COLS-1:0] key_state,
  output logic                             key_event,
  output logic      [5:0]                  key_code,
  output logic                             key_release,
  output logic                             debounce_active,
  output logic                             seq_reset
);
  import kpgf_pkg::*;

  localparam int N = ROWS * COLS;

  // ------------------------------------------------------------------
  // Pointer
  // ------------------------------------------------------------------
  // Reads and writes both count as data bytes for the advance.
  kpgf_ptr u_ptr (
    .clock     (clock),
    .rst_b     (rst_b),
    .cmd_valid (cmd_valid),
    .cmd_byte  (cmd_byte),
    .data_done (wr_valid | rd_done),
    .burst     (burst),
    .ptr       (ptr)
  );

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  // All state except the pointer, which u_ptr holds, sits in one record; the next-state copy is filled below.
  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sample;
    logic [N-1:0] stable;
    logic [23:0]  cnt;
    kpgf_seq_t    seq;
    logic [7:0]   cfg;
    logic         ev;
    logic [5:0]   code;
    logic         rel;
  } kpgf_st_t;

  kpgf_st_t s_q;
  kpgf_st_t s_d;

  // ------------------------------------------------------------------
  // Ghost filter
  // ------------------------------------------------------------------
  // A key is a ghost source if, with the accepted set, it closes a rectangle.
  // Chords that must always register have to avoid rectangle corners in the
  // wiring, since four shorted keys cannot be told apart.
  function automatic logic makes_ghost(input logic [N-1:0] held, input int k);
    int r;
    int c;
    int r2;
    int c2;
    logic g;
    r = k / COLS;
    c = k % COLS;
    g = 1'b0;
    for (r2 = 0; r2 < ROWS; r2++) begin
      for (c2 = 0; c2 < COLS; c2++) begin
        if (r2 != r && c2 != c) begin
          if ((held[r*COLS+c2] && held[r2*COLS+c]) ||
              (held[r*COLS+c2] && held[r2*COLS+c2]) ||
              (held[r2*COLS+c] && held[r2*COLS+c2])) begin
            g = 1'b1;
          end
        end
      end
    end
    makes_ghost = g;
  endfunction

  // The sense bits are read only after the second synchroniser stage.
  logic any_pressed;
  logic cfg_wr;
  assign any_pressed = |s_q.sync2;
  assign cfg_wr      = wr_valid && (ptr == ADDR_CFG);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic found;
    found = 1'b0;
    s_d = s_q;
    s_d.sync1 = key_sense;
    s_d.sync2 = s_q.sync1;
    s_d.ev = 1'b0;

    if (cfg_wr) begin
      s_d.cfg = wr_data; // [R8]
    end

    // The gate follows the value being written, so the sequencer is already idle
    // in the first cycle in which the cleared bit can be read back.
    if (!s_d.cfg[CFG_RUN_BIT]) begin
      s_d.seq = KPGF_IDLE; // [R8] [R10]
      s_d.cnt = DEB_CNT_RESET;
      s_d.stable = '0;
      s_d.sample = '0;
    end else begin
      case (s_q.seq)
        KPGF_IDLE: begin
          // Releases are settled as well, so idle is left while keys are still accepted.
          if (any_pressed || s_q.stable != '0) begin
            s_d.sample = s_q.sync2;
            s_d.cnt = DEB_CNT_RESET;
            s_d.seq = KPGF_DEBOUNCE; // [R6]
          end
        end
        KPGF_DEBOUNCE: begin
          // Any change in the sampled set restarts the settle count.
          if (s_q.sync2 != s_q.sample) begin
            s_d.sample = s_q.sync2;
            s_d.cnt = DEB_CNT_RESET;
          end else if (s_q.cnt == 24'(DEB_CYCLES - 1)) begin
            s_d.seq = KPGF_REPORT;
          end else begin
            s_d.cnt = s_q.cnt + 24'h000001;
          end
        end
        KPGF_REPORT: begin
          // One change is reported per pass so the queue sees single events.
          for (int k = 0; k < N; k++) begin
            if (!found && s_q.stable[k] && !s_q.sample[k] && !queue_full) begin
              found = 1'b1;
              s_d.stable[k] = 1'b0;
              s_d.ev = 1'b1;
              s_d.code = 6'(k);
              s_d.rel = 1'b1;
            end else if (!found && !s_q.stable[k] && s_q.sample[k] && !queue_full &&
                         !makes_ghost(s_q.stable, k)) begin // [R4] [R5]
              found = 1'b1;
              s_d.stable[k] = 1'b1;
              s_d.ev = 1'b1;
              s_d.code = 6'(k);
              s_d.rel = 1'b0;
            end
          end
          // A full queue keeps the pass open, so a change held back is reported
          // once space returns instead of being lost.
          if (!found && !queue_full) begin
            s_d.seq = KPGF_HELD; // [R5]
          end
        end
        KPGF_HELD: begin
          if (s_q.sync2 != s_q.sample) begin
            s_d.seq = KPGF_IDLE;
          end
        end
        default: begin
          s_d.seq = KPGF_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q.sync1  <= '0;
      s_q.sync2  <= '0;
      s_q.sample <= '0;
      s_q.stable <= '0;
      s_q.cnt    <= DEB_CNT_RESET;
      s_q.seq    <= KPGF_IDLE;
      s_q.cfg    <= CFG_RESET; // [R7]
      s_q.ev     <= 1'b0;
      s_q.code   <= 6'h00;
      s_q.rel    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Debounce activity is decoded from the state, so it drops in the same
  // cycle in which the sequencer leaves the settle wait.
  assign cfg             = s_q.cfg;
  assign key_state       = s_q.stable;
  assign key_event       = s_q.ev;
  assign key_code        = s_q.code;
  assign key_release     = s_q.rel;
  assign debounce_active = (s_q.seq == KPGF_DEBOUNCE);
  assign seq_reset       = ~s_q.cfg[CFG_RUN_BIT];
endmodule

// [rtl/kpgf_pkg.sv]
/*
  Shared constants for the key-matrix pointer, ghost filter and sequencer block.
  Assumes an upstream I2C target that decodes bytes into simple strobes.
*/
package kpgf_pkg;
  localparam int          ROWS       = 8;
  localparam int          COLS       = 8;
  localparam logic [7:0]  ADDR_FIFO  = 8'h00;
  localparam logic [7:0]  ADDR_CFG   = 8'h01;
  localparam logic [7:0]  ADDR_LAST  = 8'h06;
  localparam logic [7:0]  ADDR_STEP  = 8'h01;
  localparam int          CFG_RUN_BIT = 7;
  localparam logic [7:0]  CFG_RESET  = 8'h80;
  localparam logic [7:0]  PTR_RESET  = 8'h00;
  // A short settle window keeps chords responsive; very bouncy contacts may need more.
  localparam int          DEB_NS     = 10000;
  localparam int          CLK_NS     = 10;
  localparam int          DEB_CYCLES = DEB_NS / CLK_NS;
  localparam logic [23:0] DEB_CNT_RESET = 24'h000000;

  typedef enum logic [1:0] {KPGF_IDLE, KPGF_DEBOUNCE, KPGF_REPORT, KPGF_HELD} kpgf_seq_t;
endpackage

// [rtl/kpgf_ptr.sv]
/*
  Stored register pointer with burst autoincrement.
  Assumes the I2C front end pulses the strobes once per byte on the same clock.
*/
module kpgf_ptr
  import kpgf_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       data_done,
  input  wire logic       burst,
  output logic      [7:0] ptr
);
  typedef struct packed {
    logic [7:0] ptr;
  } kpgf_ptr_st_t;

  kpgf_ptr_st_t s_q;
  kpgf_ptr_st_t s_d;

  function automatic logic [7:0] next_addr(input logic [7:0] a);
    if (a == ADDR_FIFO) begin
      next_addr = ADDR_FIFO;
    end else if (a >= ADDR_LAST) begin
      next_addr = ADDR_FIFO;
    end else begin
      next_addr = a + ADDR_STEP;
    end
  endfunction

  always_comb begin
    s_d = s_q;
    if (cmd_valid) begin
      s_d.ptr = cmd_byte;
    end else if (data_done && burst) begin
      s_d.ptr = next_addr(s_q.ptr); // [R2] [R3] [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q.ptr <= PTR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign ptr = s_q.ptr;
endmodule

// [tb/kpgf_host.sv]
/*
  Host model: issues command, write and read byte strobes.
  Assumes the bench clock; strobes change 1 ns after a rising edge.
*/
module kpgf_host (
  input  wire logic       clock,
  output logic            cmd_valid,
  output logic      [7:0] cmd_byte,
  output logic            wr_valid,
  output logic      [7:0] wr_data,
  output logic            rd_done,
  output logic            burst
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_valid, cmd_byte, wr_valid, wr_data, rd_done, burst} = '0;
  // A read follows its pointer write after one idle cycle, as with a repeated start.
  task automatic op(input int k, input logic [7:0] b, input logic bu);
    @(posedge clock);
    #1;
    burst = bu;
    cmd_byte = b;
    wr_data = b;
    cmd_valid = (k == 0);
    wr_valid = (k == 1);
    rd_done = (k == 2);
    @(posedge clock);
    #1;
    {cmd_valid, wr_valid, rd_done} = '0;
    // Released bytes show the inverse so stale values cannot match.
    cmd_byte = ~b;
    wr_data = ~b;
  endtask
endmodule

// [tb/kpgf_top_properties.sv]
/*
  Port checker for kpgf_top.
  Assumes it is bound to every kpgf_top instance.
*/
module kpgf_chk (
  input logic                                    clock,
  input logic                                    rst_b,
  input logic                                    cmd_valid,
  input logic [7:0]                              cmd_byte,
  input logic                                    wr_valid,
  input logic [7:0]                              wr_data,
  input logic                                    rd_done,
  input logic                                    burst,
  input logic [kpgf_pkg::ROWS*kpgf_pkg::COLS-1:0] key_sense,
  input logic                                    queue_full,
  input logic [7:0]                              ptr,
  input logic [7:0]                              cfg,
  input logic [kpgf_pkg::ROWS*kpgf_pkg::COLS-1:0] key_state,
  input logic                                    key_event,
  input logic                                    debounce_active,
  input logic                                    seq_reset
);
  import kpgf_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic adv;
  assign adv = !cmd_valid && (wr_valid || rd_done) && burst;
  ptr_load_a: assert property (cmd_valid |=> ptr == $past(cmd_byte)) else $error("ptr load");
  ptr_hold_a: assert property (adv && ptr == 8'h00 |=> ptr == 8'h00) else $error("ptr hold");
  ptr_wrap_a: assert property (adv && ptr == 8'h06 |=> ptr == 8'h00) else $error("ptr wrap");
  ptr_incr_a: assert property (adv && ptr inside {[8'h01:8'h05]} |=> ptr == $past(ptr) + 8'h01)
    else $error("ptr incr");
  single_hold_a: assert property (!cmd_valid && !burst |=> $stable(ptr)) else $error("ptr moved");
  cfg_write_a: assert property (wr_valid && ptr == 8'h01 |=> cfg == $past(wr_data)) else $error("cfg");
  seq_hold_a: assert property (seq_reset |-> !debounce_active && !key_event) else $error("seq");
  deb_gate_a: assert property (!debounce_active && key_state == '0 && key_sense == '0 &&
    $past(key_sense) == '0 && $past(key_sense, 2) == '0 |=> !debounce_active) else $error("deb");
  full_block_a: assert property (queue_full && $past(queue_full) |-> !key_event) else $error("full");
  wrap_c: cover property (adv && ptr == 8'h06);
  swreset_c: cover property (seq_reset ##[1:20] !seq_reset);
  deb_c: cover property (debounce_active);
endmodule
bind kpgf_top kpgf_chk i_kpgf_chk (.*);

// [tb/kpgf_top_test.sv]
/*
  Self-checking bench for kpgf_top with a host model and a reference model.
  Assumes a 100 MHz clock and the package settle count for key reports.
*/
module kpgf_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import kpgf_pkg::*;
  logic clock = 0, rst_b = 0, cmd_valid, wr_valid, rd_done, burst, queue_full = 0;
  logic [7:0] cmd_byte, wr_data, ptr, cfg;
  logic [63:0] key_sense = '0;
  logic debounce_active, seq_reset, key_event, key_release;
  logic [5:0] key_code;
  logic [63:0] key_state, want, acc = '0;
  int fails = 0, compares = 0, mp = 0, mc = 8'h80;
  int evq[$];
  logic [15:0] lf = 16'd27518;
  always #5 clock = ~clock;
  kpgf_host i_kpgf_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_valid(wr_valid),
    .wr_data(wr_data), .rd_done(rd_done), .burst(burst));
  kpgf_top i_kpgf_top (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_done(rd_done), .burst(burst), .key_sense(key_sense),
    .queue_full(queue_full), .ptr(ptr), .cfg(cfg), .key_state(key_state), .key_event(key_event),
    .key_code(key_code), .key_release(key_release), .debounce_active(debounce_active), .seq_reset(seq_reset));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask
  task automatic xfer(input int k, input logic [7:0] b, input logic bu);
    i_kpgf_host.op(k, b, bu);
    if (k == 0) mp = b;
    else begin
      if (k == 1 && mp == 1) mc = b;
      if (bu) mp = (mp == 0) ? 0 : (mp >= 6) ? 0 : mp + 1;
    end
    chk("ptr", mp[7:0], ptr);
    chk("cfg", mc[7:0], cfg);
  endtask
  // A new key is a ghost source when two other corners of one of its rectangles are held.
  function automatic logic ghost(input logic [63:0] held, input int k);
    int n;
    ghost = 1'b0;
    for (int r = 0; r < ROWS; r++) begin
      for (int c = 0; c < COLS; c++) begin
        if (r != k / COLS && c != k % COLS) begin
          n = held[(k / COLS) * COLS + c] + held[r * COLS + k % COLS] + held[r * COLS + c];
          if (n >= 2) ghost = 1'b1;
        end
      end
    end
  endfunction
  // One change per pass, lowest key first; a ghost press is never reported.
  task automatic settle(input logic [63:0] w);
    int k;
    k = 0;
    while (k < 64) begin
      if (acc[k] != w[k] && (acc[k] || !ghost(acc, k))) begin
        evq.push_back(acc[k] ? 64 + k : k);
        acc[k] = w[k];
        k = 0;
      end else k++;
    end
  endtask
  task automatic press(input logic [63:0] w);
    key_sense = w;
    settle(w);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk_keys();
    for (int i = 0; i < 8; i++) chk("key_state", acc[i*8 +: 8], key_state[i*8 +: 8]);
    chk("events left", 8'h00, 8'(evq.size()));
  endtask
  always @(posedge clock) begin
    #1;
    if (key_event === 1'b1) begin
      if (evq.size() == 0) begin
        compares++;
        $display("MISMATCH key_event expected none seen %h", {key_release, key_code});
        fails++;
      end else chk("key_event", 8'(evq.pop_front()), {1'b0, key_release, key_code});
    end
  end
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(CLK_NS * (6 * DEB_CYCLES + 2000));
    fails++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_b = 1;
    chk("cfg reset", 8'h80, cfg);
    for (int a = 0; a < 7; a++) begin
      xfer(0, a[7:0], 1);
      repeat (3) xfer(2, 8'h00, 1);
      xfer(0, a[7:0], 1);
      repeat (2) xfer(1, 8'(rnd()) | 8'h80, 1);
      queue_full = 1'(rnd());
    end
    xfer(0, 8'h03, 0);
    xfer(2, 8'h00, 0);
    xfer(1, 8'h55, 0);
    queue_full = 1'b0;
    want = 64'h1 | 64'h8 | 64'h10000 | (64'h1 << ((3 + rnd() % 5) * 8 + 4 + rnd() % 4));
    press(want);
    idle(5);
    chk("deb", 8'h01, {7'h0, debounce_active});
    idle(DEB_CYCLES + 20);
    chk_keys();
    chk("deb idle", 8'h00, {7'h0, debounce_active});
    queue_full = 1'b1;
    key_sense = want & ~64'h1;
    idle(DEB_CYCLES + 20);
    chk_keys();
    queue_full = 1'b0;
    settle(key_sense);
    idle(20);
    chk_keys();
    xfer(0, 8'h01, 1);
    xfer(1, 8'h00, 1);
    chk("seq_reset", 8'h01, {7'h0, seq_reset});
    chk("deb held", 8'h00, {7'h0, debounce_active});
    acc = '0;
    xfer(0, 8'h01, 1);
    xfer(1, 8'h80, 1);
    chk("seq_run", 8'h00, {7'h0, seq_reset});
    settle(key_sense);
    idle(DEB_CYCLES + 20);
    chk_keys();
    press('0);
    idle(DEB_CYCLES + 20);
    chk_keys();
    conclude();
  end
endmodule
